/* File: inc/hbid_pkg.sv */
// shared constants and types for the host bus interface dma block
package hbid_pkg;
	// slave register indices (low address bits, word addressed)
	localparam logic [1:0] REG_CSR = 2'h0;
	localparam logic [1:0] REG_BAR = 2'h1;
	localparam logic [1:0] REG_BCR = 2'h2;
	// io page base width and switch compare width
	localparam int BASE_W = 12;
	// command_status_reg fields
	localparam int CSR_EXT_HI = 15;
	localparam int CSR_EXT_LO = 14;
	localparam int CSR_FN_HI = 13;
	localparam int CSR_FN_LO = 8;
	localparam int CSR_IE_BIT = 6;
	localparam int CSR_DONE_BIT = 7;
	localparam logic [15:0] CSR_RST = 16'h0000;
	// function codes for receive data and receive queue control
	localparam logic [5:0] FN_RX_DATA = 6'h01;
	localparam logic [5:0] FN_SUPPLY_RX = 6'h02;
	localparam logic [5:0] FN_FLUSH_RXQ = 6'h30;
	// dma geometry
	localparam int ADDR_W = 18;
	localparam int BURST_WORDS = 4;
	localparam int STAGE_BYTES = 8;
	localparam int RXQ_DEPTH = 16;
	// protocol module register select codes
	localparam logic [2:0] PM_CMD = 3'h0;
	localparam logic [2:0] PM_STAT = 3'h1;
	localparam logic [2:0] PM_TXD = 3'h2;
	localparam logic [2:0] PM_RXD = 3'h3;
	localparam logic [2:0] PM_CTL = 3'h4;
	// indicator stretch time
	localparam int CLK_HZ = 25000000;
	localparam int LED_MS = 50;
	localparam int LED_CYC = CLK_HZ / 1000 * LED_MS;
	// sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_LOAD = 4'b0001,
		ST_PM_RD = 4'b0010,
		ST_BUS_REQ = 4'b0011,
		ST_BUS_XFER = 4'b0100,
		ST_PM_WR = 4'b0101,
		ST_PM_CMD = 4'b0110,
		ST_DONE = 4'b0111,
		ST_IRQ = 4'b1000
	} hbid_state_t;
endpackage : hbid_pkg

/* File: rtl/hbid_led_stretch.sv */
`timescale 1ns/10ps
// pulse stretcher for one network indicator
module hbid_led_stretch #(
	parameter int unsigned HOLD = 1250000 // minimum on time in cycles
) (
	input wire logic clk, // system clock
	input wire logic rst, // async reset
	input wire logic cond_raw, // asynchronous network condition
	output logic led // stretched indicator
);
	logic s1_q;
	logic s2_q;
	logic [20:0] cnt_q;

	// two stage synchroniser; only s2 is read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
		end else begin
			s1_q <= cond_raw;
			s2_q <= s1_q;
		end
	end

	// reload while active so the led holds its minimum time after the end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 21'h000000;
			led <= 1'b0;
		end else if (s2_q) begin
			cnt_q <= 21'(HOLD);
			led <= 1'b1;
		end else if (cnt_q != 21'h000000) begin
			cnt_q <= cnt_q - 21'h000001;
			led <= 1'b1;
		end else begin
			led <= 1'b0;
		end
	end
endmodule : hbid_led_stretch

/* File: rtl/hbid_top.sv */
`timescale 1ns/10ps
// host bus interface board: slave regs, dma engine, sequencer, indicators
// Operation
// - compare io page address with switch base on every access
// - unmatched address: ignore the transaction completely
// - low address bits pick csr, bar or bcr
// - serve word read, read-pause, word write, byte write; no dma cycles
// - read drives register onto bus; write stores bus data
// - command register write sets action flag for sequencer
// - receive dma loads 18-bit address from receive queue
// - other dma address is csr upper two bits over bar
// - byte counter loads from queue for receive, else from bcr
// - byte counter drops per byte; dma stops at zero
// - bursts of four words; last burst one to four words
// - receive queue keeps sixteen address and count pairs
// - eight byte staging buffer between bus and module
// - one sequencer does all master signalling and steering
// - indicator on times stretched to a visible minimum
// - carrier indicator lights on any cable traffic
// - collision indicator lights on any reported collision
// - transmit indicator lights while sending
// - receive indicator lights for own, multicast or loopback frames
// - module port: 8-bit data, three select lines, five registers
// - frame loaded once; module retries collisions itself
// - module holds received frames in its own buffer
// - address advances per word; count drops as words staged
// - release and rearbitrate the bus after each burst
// - on completion set done bit, interrupt if enabled
module hbid_top #(
	parameter int unsigned LED_HOLD = hbid_pkg::LED_CYC // stretch cycles
) (
	input wire logic clk, // 25 MHz clock
	input wire logic rst, // async reset, high
	input wire logic [hbid_pkg::BASE_W-1:0] base_sw, // base address switches
	input wire logic sl_req, // slave access strobe
	input wire logic [hbid_pkg::BASE_W-1:0] sl_page, // io page address
	input wire logic [1:0] sl_reg, // register word select
	input wire logic sl_wr, // 1 write, 0 read
	input wire logic sl_byte, // byte write
	input wire logic sl_hi, // byte write to upper lane
	input wire logic [15:0] sl_wdata, // write data
	output logic sl_ack, // slave done
	output logic [15:0] sl_rdata, // read data
	output logic m_req, // bus mastership request
	input wire logic m_grant, // mastership granted
	output logic m_cyc, // master cycle valid
	output logic m_wr, // master write
	output logic [hbid_pkg::ADDR_W-1:0] m_addr, // master address
	output logic [15:0] m_wdata, // master write data
	input wire logic [15:0] m_rdata, // master read data
	input wire logic m_ack, // master cycle done
	output logic irq_req, // interrupt request
	input wire logic irq_ack, // interrupt taken
	output logic [2:0] pm_sel, // module register select
	output logic [7:0] pm_dout, // module data out
	input wire logic [7:0] pm_din, // module data in
	output logic pm_dout_en_n, // low while driving module bus
	output logic pm_rd, // module read strobe
	output logic pm_wr, // module write strobe
	input wire logic pm_ready, // module ready for next byte
	input wire logic carrier_raw, // carrier sensed
	input wire logic collision_raw, // collision reported
	input wire logic transmit_raw, // module sending
	input wire logic receive_raw, // module receiving a wanted frame
	output logic carrier_led, // carrier indicator
	output logic collision_indicator, // collision indicator
	output logic transmit_indicator, // transmit indicator
	output logic receive_indicator // receive indicator
);
	logic [15:0] command_status_reg_q;
	logic [15:0] bar_q;
	logic [15:0] byte_count_reg_q;
	logic action_q;
	logic [17:0] dma_address_counter_q;
	logic [17:0] dma_byte_counter_q;
	logic [7:0] stage_q [0:hbid_pkg::STAGE_BYTES-1];
	logic [2:0] fill_q;
	logic [2:0] burst_bytes_q;
	logic [1:0] word_q;
	logic rx_dir_q;
	logic [17:0] rxq_addr [0:hbid_pkg::RXQ_DEPTH-1];
	logic [17:0] rxq_cnt [0:hbid_pkg::RXQ_DEPTH-1];
	logic [3:0] rxq_wp_q;
	logic [3:0] rxq_rp_q;
	logic [4:0] rxq_n_q;
	hbid_pkg::hbid_state_t st_q;
	logic sel;
	logic [5:0] fn;
	logic is_rx;
	logic set_done;

	// bytes in next burst: eight, or whatever is left
	function automatic logic [3:0] burst_len(input logic [17:0] left);
		burst_len = (left >= 18'd8) ? 4'h8 : left[3:0];
	endfunction : burst_len

	//////////////////////////////////////////////////////////////////////
	// slave side
	// base compare
	assign sel = sl_req && (sl_page == base_sw);
	assign fn = command_status_reg_q[hbid_pkg::CSR_FN_HI:hbid_pkg::CSR_FN_LO];
	assign is_rx = (fn == hbid_pkg::FN_RX_DATA);

	// single cycle answer; dma cycles never reach here
	// read path
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sl_ack <= 1'b0;
			sl_rdata <= 16'h0000;
		end else begin
			sl_ack <= sel;
			if (sel && !sl_wr) begin
				unique case (sl_reg)
					hbid_pkg::REG_CSR: sl_rdata <= command_status_reg_q;
					hbid_pkg::REG_BAR: sl_rdata <= bar_q;
					hbid_pkg::REG_BCR: sl_rdata <= byte_count_reg_q;
					default: sl_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// merges a byte or word write into the old value
	function automatic logic [15:0] merge(input logic [15:0] old);
		if (!sl_byte) merge = sl_wdata;
		else if (sl_hi) merge = {sl_wdata[15:8], old[7:0]};
		else merge = {old[15:8], sl_wdata[7:0]};
	endfunction : merge

	// bar and bcr writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bar_q <= 16'h0000;
			byte_count_reg_q <= 16'h0000;
		end else if (sel && sl_wr) begin
			if (sl_reg == hbid_pkg::REG_BAR) bar_q <= merge(bar_q);
			if (sl_reg == hbid_pkg::REG_BCR) byte_count_reg_q <= merge(byte_count_reg_q);
		end
	end

	// csr: software fields plus the hardware done bit; set wins over write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			command_status_reg_q <= hbid_pkg::CSR_RST;
		end else begin
			if (sel && sl_wr && sl_reg == hbid_pkg::REG_CSR)
				command_status_reg_q <= merge(command_status_reg_q);
			if (set_done)
				command_status_reg_q[hbid_pkg::CSR_DONE_BIT] <= 1'b1;
		end
	end

	// action flag, consumed by the sequencer; a new write wins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) action_q <= 1'b0;
		else if (sel && sl_wr && sl_reg == hbid_pkg::REG_CSR) action_q <= 1'b1;
		else if (st_q == hbid_pkg::ST_IDLE) action_q <= 1'b0;
	end

	//////////////////////////////////////////////////////////////////////
	// receive buffer queue
	// fifo of buffer pairs, supplied from bar/bcr
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxq_wp_q <= 4'h0;
			rxq_rp_q <= 4'h0;
			rxq_n_q <= 5'h00;
		end else if (st_q == hbid_pkg::ST_LOAD && fn == hbid_pkg::FN_FLUSH_RXQ) begin
			rxq_rp_q <= rxq_wp_q;
			rxq_n_q <= 5'h00;
		end else if (st_q == hbid_pkg::ST_LOAD && fn == hbid_pkg::FN_SUPPLY_RX) begin
			if (rxq_n_q != 5'h10) begin
				rxq_wp_q <= rxq_wp_q + 4'h1;
				rxq_n_q <= rxq_n_q + 5'h01;
			end
		end else if (st_q == hbid_pkg::ST_LOAD && is_rx && rxq_n_q != 5'h00) begin
			rxq_rp_q <= rxq_rp_q + 4'h1;
			rxq_n_q <= rxq_n_q - 5'h01;
		end
	end

	// queue storage
	always_ff @(posedge clk) begin
		if (st_q == hbid_pkg::ST_LOAD && fn == hbid_pkg::FN_SUPPLY_RX && rxq_n_q != 5'h10) begin
			rxq_addr[rxq_wp_q] <= {command_status_reg_q[15:14], bar_q};
			rxq_cnt[rxq_wp_q] <= {2'b00, byte_count_reg_q};
		end
	end

	//////////////////////////////////////////////////////////////////////
	// command and dma sequencer
	// one machine for master signals, steering and commands
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= hbid_pkg::ST_IDLE;
		end else begin
			unique case (st_q)
				hbid_pkg::ST_IDLE: if (action_q) st_q <= hbid_pkg::ST_LOAD;
				hbid_pkg::ST_LOAD:
					if (fn == hbid_pkg::FN_SUPPLY_RX || fn == hbid_pkg::FN_FLUSH_RXQ)
						st_q <= hbid_pkg::ST_DONE;
					else if (is_rx && rxq_n_q == 5'h00) st_q <= hbid_pkg::ST_DONE;
					else st_q <= hbid_pkg::ST_PM_CMD;
				hbid_pkg::ST_PM_CMD:
					if (dma_byte_counter_q == 18'h00000) st_q <= hbid_pkg::ST_DONE;
					else if (is_rx) st_q <= hbid_pkg::ST_PM_RD;
					else st_q <= hbid_pkg::ST_BUS_REQ;
				hbid_pkg::ST_PM_RD:
					if (pm_ready && {1'b0, fill_q} == 4'(burst_bytes_q - 3'h1))
						st_q <= hbid_pkg::ST_BUS_REQ;
				hbid_pkg::ST_BUS_REQ: if (m_grant) st_q <= hbid_pkg::ST_BUS_XFER;
				hbid_pkg::ST_BUS_XFER:
					if (m_ack && ({word_q, 1'b1} >= 3'(burst_bytes_q - 3'h1)))
						st_q <= rx_dir_q ? (dma_byte_counter_q == 18'h00000 ?
							hbid_pkg::ST_DONE : hbid_pkg::ST_PM_RD) : hbid_pkg::ST_PM_WR;
				hbid_pkg::ST_PM_WR:
					if (pm_ready && fill_q == 3'(burst_bytes_q - 3'h1))
						st_q <= (dma_byte_counter_q == 18'h00000) ?
							hbid_pkg::ST_DONE : hbid_pkg::ST_BUS_REQ;
				hbid_pkg::ST_DONE:
					st_q <= command_status_reg_q[hbid_pkg::CSR_IE_BIT] ?
						hbid_pkg::ST_IRQ : hbid_pkg::ST_IDLE;
				hbid_pkg::ST_IRQ: if (irq_ack) st_q <= hbid_pkg::ST_IDLE;
				default: st_q <= hbid_pkg::ST_IDLE;
			endcase
		end
	end
	assign set_done = (st_q == hbid_pkg::ST_DONE);

	// dma counters; burst size is latched from bytes remaining
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dma_address_counter_q <= 18'h00000;
			dma_byte_counter_q <= 18'h00000;
			burst_bytes_q <= 3'h0;
			rx_dir_q <= 1'b0;
			word_q <= 2'h0;
		end else begin
			if (st_q == hbid_pkg::ST_LOAD) begin
				rx_dir_q <= is_rx;
				// receive source is the queue head
				// an empty queue leaves the counters alone rather than load unwritten slots
				if (is_rx) begin
					if (rxq_n_q != 5'h00) begin
						dma_address_counter_q <= rxq_addr[rxq_rp_q];
						dma_byte_counter_q <= rxq_cnt[rxq_rp_q];
					end
				end else begin
					dma_address_counter_q <= {command_status_reg_q[15:14], bar_q};
					dma_byte_counter_q <= {2'b00, byte_count_reg_q};
				end
			end
			// advance per word, count bytes down to zero
			if (st_q == hbid_pkg::ST_BUS_XFER && m_ack) begin
				word_q <= word_q + 2'h1;
				dma_address_counter_q <= dma_address_counter_q + 18'h00002;
				if (!rx_dir_q)
					dma_byte_counter_q <= (dma_byte_counter_q > 18'h00001) ?
						dma_byte_counter_q - 18'h00002 : 18'h00000;
			end
			if (st_q == hbid_pkg::ST_PM_RD && pm_ready && dma_byte_counter_q != 18'h00000)
				dma_byte_counter_q <= dma_byte_counter_q - 18'h00001;
			// burst sizing, 8 encoded as 0
			// placed last so the word reset beats the per-word advance on a receive burst's final ack
			if (st_q == hbid_pkg::ST_PM_CMD || (st_q == hbid_pkg::ST_PM_WR && pm_ready &&
					fill_q == 3'(burst_bytes_q - 3'h1)) || (st_q == hbid_pkg::ST_BUS_XFER && m_ack &&
					rx_dir_q && {word_q, 1'b1} >= 3'(burst_bytes_q - 3'h1))) begin
				burst_bytes_q <= 3'(burst_len(dma_byte_counter_q));
				word_q <= 2'h0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fill_q <= 3'h0;
		end else if ((st_q == hbid_pkg::ST_PM_RD || st_q == hbid_pkg::ST_PM_WR) && pm_ready) begin
			fill_q <= fill_q + 3'h1;
			if (st_q == hbid_pkg::ST_PM_RD) stage_q[fill_q] <= pm_din;
		end else if (st_q == hbid_pkg::ST_BUS_XFER && m_ack) begin
			fill_q <= 3'h0;
			if (!rx_dir_q) begin
				stage_q[{word_q, 1'b0}] <= m_rdata[7:0];
				stage_q[{word_q, 1'b1}] <= m_rdata[15:8];
			end
		end else if (st_q == hbid_pkg::ST_PM_CMD) begin
			fill_q <= 3'h0;
		end
	end

	// master bus signals
	assign m_req = (st_q == hbid_pkg::ST_BUS_REQ);
	assign m_cyc = (st_q == hbid_pkg::ST_BUS_XFER);
	assign m_wr = rx_dir_q;
	assign m_addr = dma_address_counter_q;
	assign m_wdata = {stage_q[{word_q, 1'b1}], stage_q[{word_q, 1'b0}]};
	assign irq_req = (st_q == hbid_pkg::ST_IRQ);

	// module port; frame buffering is inside the module
	assign pm_sel = (st_q == hbid_pkg::ST_PM_CMD) ? hbid_pkg::PM_CMD :
		(st_q == hbid_pkg::ST_PM_RD) ? hbid_pkg::PM_RXD : hbid_pkg::PM_TXD;
	assign pm_dout = (st_q == hbid_pkg::ST_PM_CMD) ? {2'b00, fn} : stage_q[fill_q];
	assign pm_dout_en_n = !(st_q == hbid_pkg::ST_PM_CMD || st_q == hbid_pkg::ST_PM_WR);
	assign pm_wr = (st_q == hbid_pkg::ST_PM_CMD) || (st_q == hbid_pkg::ST_PM_WR && pm_ready);
	assign pm_rd = (st_q == hbid_pkg::ST_PM_RD && pm_ready);

	//////////////////////////////////////////////////////////////////////
	// stretched indicators
	hbid_led_stretch #(.HOLD(LED_HOLD)) u_cs (.clk(clk), .rst(rst),
		.cond_raw(carrier_raw), .led(carrier_led));
	hbid_led_stretch #(.HOLD(LED_HOLD)) u_cp (.clk(clk), .rst(rst),
		.cond_raw(collision_raw), .led(collision_indicator));
	hbid_led_stretch #(.HOLD(LED_HOLD)) u_tx (.clk(clk), .rst(rst),
		.cond_raw(transmit_raw), .led(transmit_indicator));
	hbid_led_stretch #(.HOLD(LED_HOLD)) u_rx (.clk(clk), .rst(rst),
		.cond_raw(receive_raw), .led(receive_indicator));
endmodule : hbid_top

/* File: verification/hbid_top_properties.sv */
// port timing checker for the host bus interface dma top
`timescale 1ns/10ps
module hbid_top_properties #(
	parameter int unsigned LED_HOLD = 20 // stretch cycles
) (
	input wire logic clk, // clock
	input wire logic rst, // async reset
	input wire logic [hbid_pkg::BASE_W-1:0] base_sw, // base switches
	input wire logic sl_req, // slave strobe
	input wire logic [hbid_pkg::BASE_W-1:0] sl_page, // io page
	input wire logic sl_ack, // slave done
	input wire logic m_req, // bus request
	input wire logic m_cyc, // master cycle
	input wire logic m_ack, // master done
	input wire logic [hbid_pkg::ADDR_W-1:0] m_addr, // master address
	input wire logic irq_req, // interrupt request
	input wire logic irq_ack, // interrupt taken
	input wire logic pm_wr, // module write
	input wire logic pm_rd, // module read
	input wire logic pm_dout_en_n, // module bus drive
	input wire logic carrier_raw, // carrier sensed
	input wire logic carrier_led, // carrier indicator
	input wire logic transmit_raw, // sending
	input wire logic transmit_indicator // transmit indicator
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [2:0] words_q;
	logic step_q;
	logic [hbid_pkg::ADDR_W-1:0] last_q;
	int unsigned low_q;
	//////////////////////////////////////////////////
	// burst bookkeeping, cleared by every new bus request
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			words_q <= 3'h0;
			step_q <= 1'b0;
			last_q <= '0;
		end else if (m_req) begin
			words_q <= 3'h0;
			step_q <= 1'b0;
		end else if (m_cyc && m_ack) begin
			words_q <= (words_q == 3'h7) ? words_q : words_q + 3'h1;
			step_q <= 1'b1;
			last_q <= m_addr;
		end
	end
	// saturates so a long quiet line cannot wrap the count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			low_q <= 0;
		end else if (transmit_raw) begin
			low_q <= 0;
		end else if (low_q < 100000) begin
			low_q <= low_q + 1;
		end
	end
	//////////////////////////////////////////////////
	a_select_ack: assert property (sl_req && sl_page == base_sw |=> sl_ack)
		else $error("selected access not acknowledged");
	a_ignore_miss: assert property (sl_req && sl_page != base_sw |=> !sl_ack)
		else $error("foreign access acknowledged");
	a_burst_max: assert property (words_q <= 3'h4)
		else $error("more than four words without a new bus request");
	a_addr_step: assert property (m_cyc && step_q |-> m_addr == last_q + 18'h2)
		else $error("dma address did not advance by one word");
	a_irq_hold: assert property (irq_req && !irq_ack |=> irq_req)
		else $error("interrupt request dropped before it was taken");
	a_drive_on_write: assert property (pm_wr |-> !pm_dout_en_n)
		else $error("module write without driving the data bus");
	a_strobe_excl: assert property (!(pm_rd && pm_wr))
		else $error("module read and write strobes together");
	a_carrier_on: assert property (carrier_raw [*5] |-> carrier_led)
		else $error("carrier indicator not lit");
	a_stretch_min: assert property ($fell(transmit_indicator) |-> low_q >= LED_HOLD)
		else $error("transmit indicator not stretched");
endmodule : hbid_top_properties
bind hbid_top hbid_top_properties #(.LED_HOLD(LED_HOLD)) i_props (.clk(clk), .rst(rst),
	.base_sw(base_sw), .sl_req(sl_req), .sl_page(sl_page), .sl_ack(sl_ack), .m_req(m_req),
	.m_cyc(m_cyc), .m_ack(m_ack), .m_addr(m_addr), .irq_req(irq_req), .irq_ack(irq_ack),
	.pm_wr(pm_wr), .pm_rd(pm_rd), .pm_dout_en_n(pm_dout_en_n), .carrier_raw(carrier_raw),
	.carrier_led(carrier_led), .transmit_raw(transmit_raw),
	.transmit_indicator(transmit_indicator));

/* File: verification/hbid_host_mem.sv */
// host memory and bus arbiter model for the dma master side
`timescale 1ns/10ps
module hbid_host_mem (
	input wire logic clk, // clock
	input wire logic rst, // async reset
	input wire logic slow, // answer late when set
	input wire logic m_req, // mastership request
	input wire logic m_cyc, // master cycle valid
	input wire logic [hbid_pkg::ADDR_W-1:0] m_addr, // master address
	output logic m_grant, // mastership granted
	output logic m_ack, // master cycle done
	output logic [15:0] m_rdata // read data
);
	logic [1:0] wait_q;
	logic go;
	// a slow host makes both grant and ack wait three cycles
	assign go = !slow || wait_q == 2'h3;
	// idle read data inverts every cycle so stale values never look valid
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_q <= 2'h0;
			m_grant <= 1'b0;
			m_ack <= 1'b0;
			m_rdata <= 16'h0000;
		end else begin
			wait_q <= ((m_req || m_cyc) && !go && !m_ack) ? wait_q + 2'h1 : 2'h0;
			m_grant <= m_req && go && !m_grant;
			m_ack <= m_cyc && go && !m_ack;
			m_rdata <= (m_cyc && go && !m_ack) ? m_addr[15:0] ^ 16'hC3C3 : ~m_rdata;
		end
	end
endmodule : hbid_host_mem

/* File: verification/tb.sv */
// self-checking bench for the host bus interface dma top
`timescale 1ns/10ps
module tb;
	localparam int unsigned HOLD = 20; // short stretch keeps the run brief
	localparam logic [11:0] BASE = 12'h3A4; // switch setting under test
	logic clk, rst, sl_req, sl_wr, sl_byte, sl_hi, sl_ack, m_req, m_grant, m_cyc, m_wr, m_ack;
	logic irq_req, irq_ack, pm_dout_en_n, pm_rd, pm_wr, pm_ready, slow, req_d;
	logic [11:0] sl_page;
	logic [1:0] sl_reg;
	logic [15:0] sl_wdata, sl_rdata, m_wdata, m_rdata, w0;
	logic [17:0] m_addr, a0;
	logic [2:0] pm_sel, sel0;
	logic [7:0] pm_dout, pm_din, b0, b1, d0;
	logic [3:0] raw;
	wire [3:0] led;
	int miscompares = 0, n_tests = 0, nw, nb, nwr, npw, npr;
	hbid_top #(.LED_HOLD(HOLD)) i_dut (.clk(clk), .rst(rst), .base_sw(BASE), .sl_req(sl_req),
		.sl_page(sl_page), .sl_reg(sl_reg), .sl_wr(sl_wr), .sl_byte(sl_byte), .sl_hi(sl_hi),
		.sl_wdata(sl_wdata), .sl_ack(sl_ack), .sl_rdata(sl_rdata), .m_req(m_req),
		.m_grant(m_grant), .m_cyc(m_cyc), .m_wr(m_wr), .m_addr(m_addr), .m_wdata(m_wdata),
		.m_rdata(m_rdata), .m_ack(m_ack), .irq_req(irq_req), .irq_ack(irq_ack),
		.pm_sel(pm_sel), .pm_dout(pm_dout), .pm_din(pm_din), .pm_dout_en_n(pm_dout_en_n),
		.pm_rd(pm_rd), .pm_wr(pm_wr), .pm_ready(pm_ready), .carrier_raw(raw[0]),
		.collision_raw(raw[1]), .transmit_raw(raw[2]), .receive_raw(raw[3]),
		.carrier_led(led[0]), .collision_indicator(led[1]), .transmit_indicator(led[2]),
		.receive_indicator(led[3]));
	hbid_host_mem i_host (.clk(clk), .rst(rst), .slow(slow), .m_req(m_req), .m_cyc(m_cyc),
		.m_addr(m_addr), .m_grant(m_grant), .m_ack(m_ack), .m_rdata(m_rdata));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// module side: fresh byte each cycle, stalls every other cycle when slow
	always @(negedge clk) begin
		pm_din = pm_din + 8'h01;
		pm_ready = slow ? ~pm_ready : 1'b1;
	end
	// tally master words, bursts and module strobes
	always @(posedge clk) begin
		if (m_cyc && m_ack) begin
			if (nw == 0) {a0, w0} = {m_addr, m_wdata};
			nw++;
			if (m_wr) nwr++;
		end
		if (m_req && !req_d) nb++;
		req_d = m_req;
		if (pm_wr && npw == 0) {sel0, b0} = {pm_sel, pm_dout};
		if (pm_wr && npw == 1) b1 = pm_dout;
		if (pm_wr) npw++;
		if (pm_rd && npr == 0) d0 = pm_din;
		if (pm_rd) npr++;
	end
	task automatic results();
		if (miscompares == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic clr();
		{nw, nb, nwr, npw, npr} = '0;
	endtask : clr
	// one slave access: strobe for one cycle, ack and data land the cycle after
	task automatic acc(input logic wr, input logic [1:0] r, input logic [15:0] d,
		input logic [11:0] pg, input logic byt, output logic [15:0] q, output logic ak);
		@(negedge clk);
		{sl_req, sl_wr, sl_reg, sl_wdata, sl_page, sl_byte, sl_hi} = {1'b1, wr, r, d, pg, byt, byt};
		@(negedge clk);
		sl_req = 1'b0;
		ak = sl_ack;
		q = sl_rdata;
	endtask : acc
	task automatic wr(input logic [1:0] r, input logic [15:0] d);
		logic [15:0] q;
		logic ak;
		acc(1'b1, r, d, BASE, 1'b0, q, ak);
		chk("write ack", ak, 1);
	endtask : wr
	task automatic rd(input logic [1:0] r, output logic [15:0] q);
		logic ak;
		acc(1'b0, r, 16'h0000, BASE, 1'b0, q, ak);
	endtask : rd
	task automatic wait_done();
		logic [15:0] q;
		for (int i = 0; i < 500; i++) begin
			rd(hbid_pkg::REG_CSR, q);
			if (q[hbid_pkg::CSR_DONE_BIT] === 1'b1) return;
		end
		miscompares++;
		results();
	endtask : wait_done
	task automatic t_regs();
		logic [15:0] q;
		logic ak;
		wr(hbid_pkg::REG_BAR, 16'h1234);
		wr(hbid_pkg::REG_BCR, 16'h5678);
		acc(1'b1, hbid_pkg::REG_BAR, 16'hABCD, BASE, 1'b1, q, ak);
		rd(hbid_pkg::REG_BAR, q);
		chk("bar upper byte", q, 16'hAB34);
		rd(hbid_pkg::REG_BCR, q);
		chk("bcr", q, 16'h5678);
		rd(2'h3, q);
		chk("spare word", q, 16'h0000);
		acc(1'b1, hbid_pkg::REG_BCR, 16'h0000, BASE ^ 12'h001, 1'b0, q, ak);
		chk("foreign ack", ak, 0);
		rd(hbid_pkg::REG_BCR, q);
		chk("bcr untouched", q, 16'h5678);
	endtask : t_regs
	task automatic t_tx();
		logic [15:0] q;
		slow = 1'b1;
		wr(hbid_pkg::REG_BAR, 16'h1000);
		wr(hbid_pkg::REG_BCR, 16'h000A);
		clr();
		// extension 01, a transmit-style function, interrupt enabled
		wr(hbid_pkg::REG_CSR, 16'h6840);
		for (int i = 0; i < 3000 && irq_req !== 1'b1; i++) @(negedge clk);
		chk("irq raised", irq_req, 1);
		if (irq_req !== 1'b1) results();
		chk("words", nw, 5);
		chk("bursts", nb, 2);
		chk("start address", a0, 18'h11000);
		chk("memory writes", nwr, 0);
		chk("module writes", npw, 11);
		chk("command select", sel0, hbid_pkg::PM_CMD);
		chk("command byte", b0, 8'h28);
		chk("first byte", b1, 8'hC3);
		rd(hbid_pkg::REG_CSR, q);
		chk("done bit", q[hbid_pkg::CSR_DONE_BIT], 1);
		irq_ack = 1'b1;
		@(negedge clk);
		irq_ack = 1'b0;
		@(negedge clk);
		chk("irq cleared", irq_req, 0);
	endtask : t_tx
	task automatic supply(input logic [1:0] ext, input logic [15:0] a, input logic [15:0] n);
		wr(hbid_pkg::REG_BAR, a);
		wr(hbid_pkg::REG_BCR, n);
		wr(hbid_pkg::REG_CSR, {ext, hbid_pkg::FN_SUPPLY_RX, 8'h00});
		wait_done();
	endtask : supply
	task automatic rx_one(input logic [17:0] ea, input int ew);
		clr();
		wr(hbid_pkg::REG_CSR, {2'b00, hbid_pkg::FN_RX_DATA, 8'h00});
		wait_done();
		chk("rx words", nw, ew);
		chk("rx memory writes", nwr, ew);
		chk("rx module bytes", npr, ew * 2);
		if (ew > 0) chk("rx start", a0, ea);
		if (ew > 0) chk("rx first word", w0, {d0 + 8'h01, d0});
	endtask : rx_one
	task automatic t_led();
		for (int i = 0; i < 4; i++) begin
			raw[i] = 1'b1;
			repeat (6) @(negedge clk);
			chk("led on", led[i], 1);
			raw[i] = 1'b0;
			repeat (HOLD / 2) @(negedge clk);
			chk("led held", led[i], 1);
			repeat (HOLD) @(negedge clk);
			chk("led off", led[i], 0);
		end
	endtask : t_led
	initial begin
		{rst, sl_req, sl_wr, sl_byte, sl_hi, irq_ack, slow, req_d, pm_ready} = 9'h1FF;
		{sl_page, sl_reg, sl_wdata, pm_din, raw} = '0;
		clr();
		repeat (10) @(negedge clk);
		{rst, sl_req, sl_wr, sl_byte, sl_hi, irq_ack, slow, req_d} = 8'h00;
		t_regs();
		t_tx();
		slow = 1'b0;
		supply(2'b10, 16'h2000, 16'h0004);
		supply(2'b00, 16'h3000, 16'h0002);
		rx_one(18'h22000, 2);
		rx_one(18'h03000, 1);
		rx_one(18'h00000, 0);
		t_led();
		results();
	end
endmodule : tb
